/* File: pkg/wmc_regs.vh */
// Register map, field positions, reset values and detector counts of the wake and medium block
`ifndef WMC_REGS_VH
`define WMC_REGS_VH

`define WMC_ADDR_CONFIG      8'h00
`define WMC_ADDR_FIRST_CFG   8'h04
`define WMC_ADDR_EEPROM_CMD  8'h08
`define WMC_ADDR_PHY_ONE     8'h0C
`define WMC_ADDR_PHY_TWO     8'h10
`define WMC_ADDR_TWISTER     8'h14
`define WMC_ADDR_NODE_LO     8'h18
`define WMC_ADDR_NODE_HI     8'h1C
`define WMC_ADDR_INT_STATUS  8'h20
`define WMC_ADDR_INT_MASK    8'h24
`define WMC_ADDR_BOOT_CTRL   8'h28

`define WMC_CFG_GNT_SEL      7
`define WMC_CFG_AUTOLOAD     6
`define WMC_CFG_PATTERN_EN   5
`define WMC_CFG_LINK_WAKE    4
`define WMC_CFG_MEDIA_HI     3
`define WMC_CFG_MEDIA_LO     2
`define WMC_CFG_STRAP        1
`define WMC_CFG_B2B          0
`define WMC_CFG_RESET        8'h00

`define WMC_FIRST_PWR_WAKE   0
`define WMC_EEM_HI           7
`define WMC_EEM_LO           6
`define WMC_BOOT_UNLOCK      21

`define WMC_INT_PATTERN      0
`define WMC_INT_LINK         1

`define WMC_MEDIA_AUTO       2'h0
`define WMC_MEDIA_UTP        2'h1
`define WMC_MEDIA_MII        2'h2
`define WMC_MEDIA_AUI        2'h3

`define WMC_ADDR_BYTES       6
`define WMC_SYNC_BYTES       3'h6
`define WMC_ID_COPIES        5'h10
`define WMC_PAYLOAD_START    11'h00C
`define WMC_MIN_FRAME        11'h011
`define WMC_SYNC_BYTE        8'hFF

`endif

/* File: rtl/wmc_config.v */
// Wake and medium configuration register with its bus slave, wake logic, grant delay and medium select
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "wmc_regs.vh"

// Contract
// R01: Select bit 1 delays frame start one clock after grant; 0 adds none.
// R02: Tuning word writes accepted when auto-load is 0 and both EEPROM mode bits are 1.
// R03: Auto-load 1 loads from EEPROM and ignores tuning word writes.
// R04: EEPROM auto-load fills only the twister word, never the PHY words.
// R05: Pattern wake counts only while power wake enable is set.
// R06: A valid wake frame with wake enabled asserts the active-low power event.
// R07: Only frames addressed to this node are searched.
// R08: Wake frame needs destination, source, payload and CRC.
// R09: Destination may be own node address or any multicast, broadcast included.
// R10: Node identifier repeated sixteen times back to back, each exact.
// R11: Six bytes of FFh must directly precede the identifier copies.
// R12: Sync run and copies may start at any payload byte.
// R13: Medium select 00 auto, 01 UTP, 10 MII, 11 AUI; auto prefers UTP.
// R14: Link established with link wake and power wake on asserts power event; the code also needs power_state_ok and a rising utp_link_up.
// R15: Medium bits are written only while the unlock bit is set; the code also loads them from an EEPROM config byte without the unlock bit.

module wmc_config (
  input  wire        mclk,
  input  wire        reset,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         irq,
  input  wire        bus_request,
  input  wire        pci_gnt_n,
  output reg         frame_start_n,
  input  wire        eeprom_cfg_valid,
  input  wire [7:0]  eeprom_cfg_byte,
  input  wire        eeprom_tw_valid,
  input  wire [15:0] eeprom_tw_word,
  output reg  [15:0] phy_tuning_word_one,
  output reg  [15:0] phy_tuning_word_two,
  output reg  [15:0] twister_tuning_word,
  input  wire        port_strap_status,
  input  wire        back_to_back_enable,
  input  wire        utp_link_up,
  input  wire        alt_link_up,
  input  wire        power_state_ok,
  output reg  [1:0]  medium_active,
  output reg         power_event_out_n,
  input  wire        rx_sof,
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  input  wire        rx_eof,
  input  wire        rx_crc_ok
);

  reg  [7:0]  cfg;
  reg  [7:0]  first_cfg;
  reg  [7:0]  eeprom_cmd;
  reg  [31:0] boot_ctrl;
  reg  [47:0] node_id;
  reg  [1:0]  int_status;
  reg  [1:0]  int_mask;
  reg         strap_q;
  reg         b2b_q;
  reg         gnt_q;
  reg         utp_link_q;
  reg  [31:0] next_readdata;
  reg  [1:0]  next_status;
  reg  [1:0]  next_medium;
  wire        pattern_found;
  wire [31:0] wmask;
  wire [31:0] wr_bits;
  wire        wr_hit;
  wire        power_wake;
  wire        tuning_unlocked;
  wire        pattern_event;
  wire        link_event;

  wmc_wake_detect u_detect (
    .mclk       (mclk),
    .reset      (reset),
    .node_id    (node_id),
    .rx_sof     (rx_sof),
    .rx_valid   (rx_valid),
    .rx_byte    (rx_byte),
    .rx_eof     (rx_eof),
    .rx_crc_ok  (rx_crc_ok),
    .wake_found (pattern_found)
  );

  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_bits = avs_writedata & wmask;
  assign wr_hit = avs_write & ~avs_waitrequest;
  assign power_wake = first_cfg[`WMC_FIRST_PWR_WAKE];
  assign tuning_unlocked = ~cfg[`WMC_CFG_AUTOLOAD] & eeprom_cmd[`WMC_EEM_HI]
                           & eeprom_cmd[`WMC_EEM_LO];  // see R02 R03
  assign pattern_event = pattern_found & cfg[`WMC_CFG_PATTERN_EN] & power_wake;  // see R05 R06
  assign link_event = utp_link_up & ~utp_link_q & cfg[`WMC_CFG_LINK_WAKE]
                      & power_wake & power_state_ok;  // see R14

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [31:0] mask;
    begin
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  always @* begin
    case (avs_address)
      `WMC_ADDR_CONFIG:     next_readdata = {24'h000000, cfg[7:2], strap_q, b2b_q};
      `WMC_ADDR_FIRST_CFG:  next_readdata = {24'h000000, first_cfg};
      `WMC_ADDR_EEPROM_CMD: next_readdata = {24'h000000, eeprom_cmd};
      `WMC_ADDR_PHY_ONE:    next_readdata = {16'h0000, phy_tuning_word_one};
      `WMC_ADDR_PHY_TWO:    next_readdata = {16'h0000, phy_tuning_word_two};
      `WMC_ADDR_TWISTER:    next_readdata = {16'h0000, twister_tuning_word};
      `WMC_ADDR_NODE_LO:    next_readdata = node_id[31:0];
      `WMC_ADDR_NODE_HI:    next_readdata = {16'h0000, node_id[47:32]};
      `WMC_ADDR_INT_STATUS: next_readdata = {30'h0000000, int_status};
      `WMC_ADDR_INT_MASK:   next_readdata = {30'h0000000, int_mask};
      `WMC_ADDR_BOOT_CTRL:  next_readdata = boot_ctrl;
      default:              next_readdata = 32'h00000000;
    endcase
  end

  // Event set wins over write-one-to-clear
  always @* begin
    next_status = int_status;
    if (wr_hit && avs_address == `WMC_ADDR_INT_STATUS && avs_byteenable[0])
      next_status = int_status & ~avs_writedata[1:0];
    if (pattern_event)
      next_status[`WMC_INT_PATTERN] = 1'b1;
    if (link_event)
      next_status[`WMC_INT_LINK] = 1'b1;
  end

  always @* begin
    case (cfg[`WMC_CFG_MEDIA_HI:`WMC_CFG_MEDIA_LO])
      `WMC_MEDIA_AUTO: begin
        if (utp_link_up)
          next_medium = `WMC_MEDIA_UTP;  // see R13
        else if (alt_link_up)
          next_medium = strap_q ? `WMC_MEDIA_AUI : `WMC_MEDIA_MII;
        else
          next_medium = `WMC_MEDIA_AUTO;
      end
      default: next_medium = cfg[`WMC_CFG_MEDIA_HI:`WMC_CFG_MEDIA_LO];  // see R13
    endcase
  end

  // Avalon slave: one wait cycle, then answer
  always @(posedge mclk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      if (avs_read)
        avs_readdata <= next_readdata;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      cfg                 <= `WMC_CFG_RESET;
      first_cfg           <= 8'h00;
      eeprom_cmd          <= 8'h00;
      boot_ctrl           <= 32'h00000000;
      node_id             <= 48'h000000000000;
      int_mask            <= 2'h0;
      phy_tuning_word_one <= 16'h0000;
      phy_tuning_word_two <= 16'h0000;
      twister_tuning_word <= 16'h0000;
    end else begin
      if (eeprom_cfg_valid)
        cfg <= eeprom_cfg_byte;
      else if (wr_hit && avs_address == `WMC_ADDR_CONFIG && avs_byteenable[0]) begin
        cfg[`WMC_CFG_AUTOLOAD]   <= avs_writedata[`WMC_CFG_AUTOLOAD];
        cfg[`WMC_CFG_PATTERN_EN] <= avs_writedata[`WMC_CFG_PATTERN_EN];
        cfg[`WMC_CFG_LINK_WAKE]  <= avs_writedata[`WMC_CFG_LINK_WAKE];
        if (boot_ctrl[`WMC_BOOT_UNLOCK])
          cfg[`WMC_CFG_MEDIA_HI:`WMC_CFG_MEDIA_LO] <=
            avs_writedata[`WMC_CFG_MEDIA_HI:`WMC_CFG_MEDIA_LO];  // see R15
      end
      if (wr_hit) begin
        case (avs_address)
          `WMC_ADDR_FIRST_CFG:  first_cfg <= (first_cfg & ~wmask[7:0]) | wr_bits[7:0];
          `WMC_ADDR_EEPROM_CMD: eeprom_cmd <= (eeprom_cmd & ~wmask[7:0]) | wr_bits[7:0];
          `WMC_ADDR_BOOT_CTRL:  boot_ctrl <= merge(boot_ctrl, avs_writedata, wmask);
          `WMC_ADDR_NODE_LO:    node_id[31:0] <= merge(node_id[31:0], avs_writedata, wmask);
          `WMC_ADDR_NODE_HI:    node_id[47:32] <= (node_id[47:32] & ~wmask[15:0]) | wr_bits[15:0];
          `WMC_ADDR_INT_MASK:   int_mask <= (int_mask & ~wmask[1:0]) | wr_bits[1:0];
          default: ;
        endcase
      end
      if (wr_hit && tuning_unlocked) begin  // see R02 R03
        if (avs_address == `WMC_ADDR_PHY_ONE)
          phy_tuning_word_one <= (phy_tuning_word_one & ~wmask[15:0]) | wr_bits[15:0];
        if (avs_address == `WMC_ADDR_PHY_TWO)
          phy_tuning_word_two <= (phy_tuning_word_two & ~wmask[15:0]) | wr_bits[15:0];
        if (avs_address == `WMC_ADDR_TWISTER)
          twister_tuning_word <= (twister_tuning_word & ~wmask[15:0]) | wr_bits[15:0];
      end
      if (eeprom_tw_valid && cfg[`WMC_CFG_AUTOLOAD])
        twister_tuning_word <= eeprom_tw_word;  // see R03 R04
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      int_status        <= 2'h0;
      irq               <= 1'b0;
      power_event_out_n <= 1'b1;
      strap_q           <= 1'b0;
      b2b_q             <= 1'b0;
      gnt_q             <= 1'b0;
      utp_link_q        <= 1'b0;
      frame_start_n     <= 1'b1;
      medium_active     <= `WMC_MEDIA_AUTO;
    end else begin
      int_status        <= next_status;
      irq               <= |(next_status & int_mask);
      power_event_out_n <= ~(|next_status);  // see R06 R14
      strap_q           <= port_strap_status;
      b2b_q             <= back_to_back_enable;
      gnt_q             <= ~pci_gnt_n;
      utp_link_q        <= utp_link_up;
      frame_start_n     <= ~(bus_request & (cfg[`WMC_CFG_GNT_SEL] ? gnt_q : ~pci_gnt_n));  // see R01
      medium_active     <= next_medium;
    end
  end

endmodule

/* File: rtl/wmc_wake_detect.v */
// Wake-pattern frame detector fed byte by byte from the receive path
`timescale 1ns/1ps
`include "wmc_regs.vh"

module wmc_wake_detect (
  input  wire        mclk,
  input  wire        reset,
  input  wire [47:0] node_id,
  input  wire        rx_sof,
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  input  wire        rx_eof,
  input  wire        rx_crc_ok,
  output reg         wake_found
);

  localparam S_SYNC  = 1'b0;
  localparam S_MATCH = 1'b1;

  wire [7:0]  id_byte [0:5];
  reg  [10:0] byte_cnt;
  reg         dest_own;
  reg         dest_multi;
  reg         state;
  reg  [2:0]  sync_cnt;
  reg  [2:0]  id_idx;
  reg  [4:0]  copies;
  reg         seq_seen;
  reg         next_state;
  reg  [2:0]  next_sync;
  reg  [2:0]  next_idx;
  reg  [4:0]  next_copies;
  reg         next_seen;

  genvar g;
  generate
    for (g = 0; g < `WMC_ADDR_BYTES; g = g + 1) begin : g_id
      assign id_byte[g] = node_id[8*g+7:8*g];
    end
  endgenerate

  wire in_dest    = byte_cnt < 11'd6;
  wire in_payload = byte_cnt >= `WMC_PAYLOAD_START;
  wire is_sync    = rx_byte == `WMC_SYNC_BYTE;

  // Search restarts at any payload byte
  always @* begin
    next_state  = state;
    next_sync   = sync_cnt;
    next_idx    = id_idx;
    next_copies = copies;
    next_seen   = seq_seen;
    case (state)
      S_SYNC: begin
        if (sync_cnt == `WMC_SYNC_BYTES && rx_byte == id_byte[0]) begin  // see R11 R12
          next_state  = S_MATCH;
          next_idx    = 3'd1;
          next_copies = 5'd0;
        end else if (is_sync) begin
          next_sync = (sync_cnt == `WMC_SYNC_BYTES) ? sync_cnt : sync_cnt + 3'd1;
        end else begin
          next_sync = 3'd0;
        end
      end
      S_MATCH: begin
        if (rx_byte == id_byte[id_idx]) begin  // see R10
          if (id_idx == 3'd5) begin
            next_idx    = 3'd0;
            next_copies = copies + 5'd1;
            if (copies + 5'd1 == `WMC_ID_COPIES) begin
              next_seen  = 1'b1;
              next_state = S_SYNC;
              next_sync  = 3'd0;
            end
          end else begin
            next_idx = id_idx + 3'd1;
          end
        end else begin
          next_state = S_SYNC;
          next_sync  = is_sync ? 3'd1 : 3'd0;
        end
      end
      default: begin
        next_state = S_SYNC;
        next_sync  = 3'd0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      byte_cnt   <= 11'h000;
      dest_own   <= 1'b0;
      dest_multi <= 1'b0;
      state      <= S_SYNC;
      sync_cnt   <= 3'd0;
      id_idx     <= 3'd0;
      copies     <= 5'd0;
      seq_seen   <= 1'b0;
      wake_found <= 1'b0;
    end else begin
      wake_found <= 1'b0;
      if (rx_sof) begin
        byte_cnt   <= 11'h000;
        dest_own   <= 1'b1;
        dest_multi <= 1'b0;
        state      <= S_SYNC;
        sync_cnt   <= 3'd0;
        id_idx     <= 3'd0;
        copies     <= 5'd0;
        seq_seen   <= 1'b0;
      end else if (rx_valid) begin
        if (byte_cnt != 11'h7FF)
          byte_cnt <= byte_cnt + 11'h001;
        if (in_dest) begin
          dest_own <= dest_own & (rx_byte == id_byte[byte_cnt[2:0]]);  // see R09
          if (byte_cnt == 11'h000)
            dest_multi <= rx_byte[0];  // see R09
        end
        if (in_payload) begin  // see R07 R12
          state    <= next_state;
          sync_cnt <= next_sync;
          id_idx   <= next_idx;
          copies   <= next_copies;
          seq_seen <= next_seen;
        end
      end
      if (rx_eof)
        wake_found <= seq_seen & (dest_own | dest_multi) & rx_crc_ok
                      & (byte_cnt >= `WMC_MIN_FRAME);  // see R07 R08
    end
  end

endmodule

/* File: tb/wmc_config_properties.sv */
// Bus, grant, tuning word and wake properties of the configuration block
`timescale 1ns/1ps

module wmc_config_props (
  input logic        mclk,
  input logic        reset,
  input logic [7:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        irq,
  input logic        bus_request,
  input logic        pci_gnt_n,
  input logic        frame_start_n,
  input logic        eeprom_tw_valid,
  input logic [15:0] phy_tuning_word_one,
  input logic [15:0] phy_tuning_word_two,
  input logic        utp_link_up,
  input logic        power_event_out_n,
  input logic        rx_eof
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest;
  endsequence

  AST_WAIT_ONE: assert property (s_taken |=> s_answer) else $error("request not answered in one cycle");
  AST_WAIT_REL: assert property (s_answer |=> avs_waitrequest) else $error("wait low for two cycles");
  AST_UNMAPPED: assert property (s_taken ##0 (avs_read && avs_address > 8'h28) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_FRAME_REQ: assert property (!frame_start_n |-> $past(bus_request))
    else $error("frame without request");
  AST_FRAME_GNT: assert property ($past(pci_gnt_n) && $past(pci_gnt_n, 2) |-> frame_start_n)
    else $error("frame without grant");
  AST_PHY_HOLD: assert property (eeprom_tw_valid && !avs_write |=>
    $stable(phy_tuning_word_one) && $stable(phy_tuning_word_two)) else $error("phy word loaded");
  AST_IRQ_PEV: assert property (irq |-> !power_event_out_n) else $error("irq without event");
  AST_PEV_SET: assert property ($fell(power_event_out_n) |-> $past(rx_eof, 2) || $past(utp_link_up))
    else $error("event without cause");
  AST_PEV_CLR: assert property ($rose(power_event_out_n) |-> $past(avs_write))
    else $error("event released without clear");
endmodule

bind wmc_config wmc_config_props i_props (.mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .irq, .bus_request, .pci_gnt_n, .frame_start_n, .eeprom_tw_valid, .phy_tuning_word_one,
  .phy_tuning_word_two, .utp_link_up, .power_event_out_n, .rx_eof);

/* File: tb/wmc_config_tb.sv */
// Self-checking bench of the wake and medium configuration block
`timescale 1ns/1ps

module wmc_config_tb;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        bus_request = 1'b0;
  logic        pci_gnt_n = 1'b1;
  logic        eeprom_cfg_valid = 1'b0;
  logic [7:0]  eeprom_cfg_byte = 8'h00;
  logic        eeprom_tw_valid = 1'b0;
  logic [15:0] eeprom_tw_word = 16'h0;
  logic        port_strap_status = 1'b1;
  logic        back_to_back_enable = 1'b0;
  logic        utp_link_up = 1'b0;
  logic        alt_link_up = 1'b0;
  logic        power_state_ok = 1'b1;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, irq, frame_start_n, power_event_out_n;
  wire  [15:0] phy_tuning_word_one, phy_tuning_word_two, twister_tuning_word;
  wire  [1:0]  medium_active;
  wire         rx_sof, rx_valid, rx_eof, rx_crc_ok;
  wire  [7:0]  rx_byte;
  integer      fails = 0;
  integer      checked = 0;
  integer      i, n;
  logic [31:0] q;
  // Register rows: address, written value, value read back
  logic [7:0]  ra [14] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h3C, 8'h00, 8'h28, 8'h00, 8'h00,
    8'h0C, 8'h14};
  logic [31:0] rw [14] = '{32'h1, 32'hC0, 32'h1234, 32'h5678, 32'h9ABC, 32'h44332210, 32'h6655, 32'hFF, 32'hC,
    32'h200000, 32'hC, 32'h70, 32'hFFFF, 32'hFFFF};
  logic [31:0] re [14] = '{32'h1, 32'hC0, 32'h1234, 32'h5678, 32'h9ABC, 32'h44332210, 32'h6655, 32'h0, 32'h2,
    32'h200000, 32'hE, 32'h72, 32'h1234, 32'h9ABC};
  // Frame rows: dest kind, offset, sync count, copies, crc ok, power wake, wake expected
  logic [31:0] fr [8] = '{32'h02610111, 32'h15610111, 32'h22610110, 32'h02610010, 32'h0260F110, 32'h02510110,
    32'h02610100, 32'h37610111};

  wmc_config i_dut (.mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .irq, .bus_request, .pci_gnt_n, .frame_start_n, .eeprom_cfg_valid,
    .eeprom_cfg_byte, .eeprom_tw_valid, .eeprom_tw_word, .phy_tuning_word_one, .phy_tuning_word_two,
    .twister_tuning_word, .port_strap_status, .back_to_back_enable, .utp_link_up, .alt_link_up,
    .power_state_ok, .medium_active, .power_event_out_n, .rx_sof, .rx_valid, .rx_byte, .rx_eof, .rx_crc_ok);
  wmc_rx_src i_src (.mclk, .rx_sof, .rx_valid, .rx_byte, .rx_eof, .rx_crc_ok);

  always #12.5 mclk = ~mclk;

  task chk(input [31:0] seen, input [31:0] exp, input [8*12-1:0] what);
    begin
      checked++;
      if (seen !== exp) begin
        fails++;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] r);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    fails++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk({avs_waitrequest, irq, frame_start_n, power_event_out_n, medium_active}, 6'h2C, "reset");
    for (i = 0; i < 14; i++) begin
      bus(1'b1, ra[i], rw[i], q);
      bus(1'b0, ra[i], 32'h0, q);
      chk(q, re[i], "register");
    end
    $display("test registers done");
    eeprom_tw_word <= 16'h0F0F;
    eeprom_tw_valid <= 1'b1;
    @(posedge mclk);
    eeprom_tw_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({phy_tuning_word_one, phy_tuning_word_two}, 32'h12345678, "phy words");
    chk(twister_tuning_word, 16'h0F0F, "twister");
    $display("test autoload done");
    for (i = 0; i < 2; i++) begin
      eeprom_cfg_byte <= {i[0], 7'h70};
      eeprom_cfg_valid <= 1'b1;
      @(posedge mclk);
      eeprom_cfg_valid <= 1'b0;
      bus_request <= 1'b1;
      pci_gnt_n <= 1'b0;
      n = 0;
      do begin @(negedge mclk); n++; end while (frame_start_n !== 1'b0 && n < 9);
      chk(n, i + 2, "grant delay");
      @(posedge mclk);
      bus_request <= 1'b0;
      pci_gnt_n <= 1'b1;
      repeat (3) @(posedge mclk);
    end
    $display("test grant done");
    utp_link_up <= 1'b1;
    alt_link_up <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({irq, power_event_out_n}, 2'h0, "link wake");
    bus(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h2, "status");
    bus(1'b1, 8'h24, 32'h3, q);
    @(posedge mclk);
    chk(irq, 1'b1, "irq");
    bus(1'b1, 8'h20, 32'h2, q);
    chk({irq, power_event_out_n}, 2'h1, "clear");
    $display("test link done");
    for (n = 3; n >= 0; n--) begin
      bus(1'b1, 8'h00, {24'h0, 4'h7, n[1:0], 2'h0}, q);
      repeat (2) @(posedge mclk);
      chk(medium_active, n == 0 ? 2'h1 : n[1:0], "medium");
    end
    utp_link_up <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(medium_active, 2'h3, "auto aui");
    port_strap_status <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(medium_active, 2'h2, "auto mii");
    port_strap_status <= 1'b1;
    @(posedge mclk);
    $display("test medium done");
    for (i = 0; i < 8; i++) begin
      bus(1'b1, 8'h04, {31'h0, fr[i][4]}, q);
      i_src.send(fr[i][31:28], fr[i][27:24], fr[i][23:20], fr[i][19:12], fr[i][8]);
      repeat (4) @(posedge mclk);
      chk({irq, power_event_out_n}, {fr[i][0], !fr[i][0]}, "wake");
      bus(1'b1, 8'h20, 32'h3, q);
    end
    $display("test wake done");
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    bus(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h2, "second reset");
    chk(power_event_out_n, 1'b1, "pev reset");
    $display("test second reset done");
    print_verdict;
  end
endmodule

/* File: tb/wmc_rx_src.sv */
// Receive frame source that feeds the wake detector byte by byte
`timescale 1ns/1ps

module wmc_rx_src #(
  parameter [47:0] NODE = 48'h665544332210
) (
  input  wire       mclk,
  output reg        rx_sof,
  output reg        rx_valid,
  output reg  [7:0] rx_byte,
  output reg        rx_eof,
  output reg        rx_crc_ok
);
  initial begin
    rx_sof = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_eof = 1'b0;
    rx_crc_ok = 1'b0;
  end

  task put(input [7:0] b);
    begin
      rx_valid <= 1'b1;
      rx_byte <= b;
      @(posedge mclk);
    end
  endtask

  // Destination kinds: own node, broadcast, foreign unicast, multicast
  task send(input [3:0] dk, input [3:0] off, input [3:0] ns, input [7:0] nc, input crc);
    integer k;
    begin
      rx_sof <= 1'b1;
      @(posedge mclk);
      rx_sof <= 1'b0;
      for (k = 0; k < 6; k++) put(dk == 4'h0 ? NODE[8*k+:8] : dk == 4'h1 ? 8'hFF : dk == 4'h2 ? 8'h02 : 8'h01);
      for (k = 0; k < 6; k++) put(8'h0A);
      for (k = 0; k < off; k++) put(8'h00);
      for (k = 0; k < ns; k++) put(8'hFF);
      for (k = 0; k < 6 * nc; k++) put(NODE[8*(k%6)+:8]);
      for (k = 0; k < 4; k++) put(8'h5A);
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte;
      rx_eof <= 1'b1;
      rx_crc_ok <= crc;
      @(posedge mclk);
      rx_eof <= 1'b0;
      rx_crc_ok <= 1'b0;
    end
  endtask
endmodule
